// ==== psp_regs.svh ====
`ifndef PSP_REGS_SVH
`define PSP_REGS_SVH

// register word indices; byte address = 4 * index
`define PSP_IDX_DATA      8'h08
`define PSP_IDX_PORT_E_PINS     8'h09
`define PSP_IDX_IRQFLAG   8'h0C
`define PSP_IDX_DIRSTAT   8'h89
`define PSP_IDX_IRQEN     8'h8C
`define PSP_IDX_ANACFG    8'h9F

// port_e_dir_and_slave_status fields
`define PSP_BIT_IBF       7
`define PSP_BIT_OBF       6
`define PSP_BIT_IN_BUFFER_OVERRUN      5
`define PSP_BIT_MODE      4
// irq flag / enable field
`define PSP_BIT_IRQ       7

// reset values
`define PSP_RST_DIRSTAT   8'h07
`define PSP_RST_IRQFLAG   8'h00
`define PSP_RST_IRQEN     8'h00
`define PSP_RST_ANACFG    8'h00

// analog config: value range that makes port-E pins digital
`define PSP_ANA_DIGITAL_MIN 4'h6

// instruction cycle phase count (Q1..Q4)
`define PSP_PHASES        4

`endif

// ==== psp_pkg.sv ====
package psp_pkg;
    typedef struct packed {
        logic       paddrOk;
        logic [7:0] index;
    } psp_addr_t;

    // bit order follows the port-E pins: [2] chip select, [1] write, [0] read
    typedef struct packed {
        logic csN;
        logic wrN;
        logic rdN;
    } psp_strobe_t;

    typedef enum logic [3:0] {
        PSP_Q1 = 4'h1,
        PSP_Q2 = 4'h2,
        PSP_Q3 = 4'h4,
        PSP_Q4 = 4'h8
    } psp_phase_t;

    typedef enum logic [2:0] {
        PSP_IDLE    = 3'h1,
        PSP_ACTIVE  = 3'h2,
        PSP_WAIT_Q2 = 3'h4
    } psp_xfer_t;
endpackage : psp_pkg

// ==== psp_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module psp_sync
    import psp_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] stage1Reg;

    // first stage feeds only the second; resets high so strobes start idle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stage1Reg <= '1;
            dout      <= '1;
        end else begin
            stage1Reg <= din;
            dout      <= stage1Reg;
        end
    end
endmodule : psp_sync
`default_nettype wire

// ==== psp_phase_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
module psp_phase_gen
    import psp_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst,
    output var psp_phase_t phase
);
    // one core clock per phase; four make an instruction cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            phase <= PSP_Q1;
        end else begin
            case (phase)
                PSP_Q1:  phase <= PSP_Q2;
                PSP_Q2:  phase <= PSP_Q3;
                PSP_Q3:  phase <= PSP_Q4;
                PSP_Q4:  phase <= PSP_Q1;
                default: phase <= PSP_Q1;
            endcase
        end
    end
endmodule : psp_phase_gen
`default_nettype wire

// ==== psp_slave_port.sv ====
// Functional notes
// - slave-port select bit makes the data port a host-accessible slave port
// - select bit turns port-E pins 0,1,2 into read, write, chip-select strobes
// - read strobe low with chip select low is a host read
// - write strobe low with chip select low is a host write
// - chip select is active low; strobes ignored while it is high
// - two latches at one address: firmware writes output, reads input
// - in slave mode the data-pin direction follows host strobes only
// - host write starts on first low detection; port data captured
// - write end sets input-full at phase four after next phase two
// - same phase four also sets the slave-port interrupt flag
// - in slave mode input-full cleared only by firmware read of the data port
// - second host write before firmware read sets input overrun
// - host read start clears output-full at once
// - read end sets interrupt flag at phase four after next phase two
// - output-full stays low until firmware writes the data port
// - outside slave mode full flags held clear; overrun stays until cleared
// - outside slave mode port-E pins are general I/O by direction bits
// - port-E pin set analog reads as zero
// - after reset port-E pins are analog inputs
`timescale 1ns/1ps
`default_nettype none
`include "psp_regs.svh"
module psp_slave_port
    import psp_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  dataPinIn,
    output logic      [7:0]  dataPinOut,
    output logic      [7:0]  dataPinOe,
    input  wire logic [7:0]  portDDirection,
    input  wire logic [2:0]  portEPinIn,
    output logic      [2:0]  portEPinOut,
    output logic      [2:0]  portEPinOe,
    output logic             slavePortIrq
);
    psp_phase_t  phase;
    psp_strobe_t strbSync;
    logic [7:0]  dataSync;
    psp_addr_t   addr;

    logic [7:0] outLatchReg;
    logic [7:0] inLatchReg;
    logic [2:0] portELatchReg;
    logic [2:0] dirReg;
    logic       modeReg;
    logic       ibfReg;
    logic       obfReg;
    logic       ibovReg;
    logic       irqFlagReg;
    logic [6:0] irqFlagOtherReg;
    logic [7:0] irqEnReg;
    logic [7:0] anaCfgReg;
    psp_xfer_t  wrStateReg;
    psp_xfer_t  rdStateReg;
    logic       wrDone;
    logic       rdDone;
    logic       rdStart;
    logic       wrStart;
    logic       pinsDigital;

    psp_phase_gen u_phase (
        .clk_sys (clk_sys),
        .rst     (rst),
        .phase   (phase)
    );

    psp_sync #(.W(3)) u_sync_strb (
        .clk_sys (clk_sys),
        .rst     (rst),
        .din     (portEPinIn),
        .dout    (strbSync)
    );

    psp_sync #(.W(8)) u_sync_data (
        .clk_sys (clk_sys),
        .rst     (rst),
        .din     (dataPinIn),
        .dout    (dataSync)
    );

    // APB: zero-wait slave, word aligned index = paddr[9:2]
    assign addr = {(paddr[31:10] == 22'h000000) && (paddr[1:0] == 2'h0),
                   paddr[9:2]};
    assign pready       = 1'b1;

    logic apbAcc;
    logic apbWr;
    logic apbRd;
    logic mapped;
    assign apbAcc = psel && penable;
    always_comb begin
        case (addr.index)
            `PSP_IDX_DATA, `PSP_IDX_PORT_E_PINS, `PSP_IDX_IRQFLAG,
            `PSP_IDX_DIRSTAT, `PSP_IDX_IRQEN, `PSP_IDX_ANACFG: mapped = addr.paddrOk;
            default: mapped = 1'b0;
        endcase
    end
    assign pslverr = apbAcc && !mapped;
    assign apbWr   = apbAcc && pwrite && mapped;
    assign apbRd   = apbAcc && !pwrite && mapped;

    logic wrData;
    logic rdData;
    logic wrDirStat;
    logic wrIrqFlag;
    assign wrData    = apbWr && addr.index == `PSP_IDX_DATA;
    assign rdData    = apbRd && addr.index == `PSP_IDX_DATA;
    assign wrDirStat = apbWr && addr.index == `PSP_IDX_DIRSTAT;
    assign wrIrqFlag = apbWr && addr.index == `PSP_IDX_IRQFLAG;

    // config bits 3:0 at 0x6 and up leave port-E digital; reset value 0 keeps them analog
    assign pinsDigital = anaCfgReg[3:0] >= `PSP_ANA_DIGITAL_MIN;

    logic csLow;
    assign csLow   = modeReg && !strbSync.csN;
    assign wrStart = csLow && !strbSync.wrN;
    assign rdStart = csLow && !strbSync.rdN;

    // per-direction transfer tracker: active until a level goes high, then
    // waits for phase two, and completes at the following phase four
    function automatic psp_xfer_t xferNext(input psp_xfer_t st, input logic act,
                                           input psp_phase_t ph);
        case (st)
            PSP_IDLE:    xferNext = act ? PSP_ACTIVE : PSP_IDLE;
            PSP_ACTIVE:  xferNext = act ? PSP_ACTIVE : PSP_WAIT_Q2;
            PSP_WAIT_Q2: xferNext = (ph == PSP_Q4) ? PSP_IDLE : PSP_WAIT_Q2;
            default:     xferNext = PSP_IDLE;
        endcase
    endfunction : xferNext

    logic wrSawQ2Reg;
    logic rdSawQ2Reg;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wrStateReg <= PSP_IDLE;
            rdStateReg <= PSP_IDLE;
            wrSawQ2Reg <= 1'b0;
            rdSawQ2Reg <= 1'b0;
        end else if (!modeReg) begin
            wrStateReg <= PSP_IDLE;
            rdStateReg <= PSP_IDLE;
            wrSawQ2Reg <= 1'b0;
            rdSawQ2Reg <= 1'b0;
        end else begin
            wrStateReg <= (wrStateReg == PSP_WAIT_Q2 && !wrSawQ2Reg) ? PSP_WAIT_Q2
                          : xferNext(wrStateReg, wrStart, phase);
            rdStateReg <= (rdStateReg == PSP_WAIT_Q2 && !rdSawQ2Reg) ? PSP_WAIT_Q2
                          : xferNext(rdStateReg, rdStart, phase);
            wrSawQ2Reg <= (wrStateReg == PSP_WAIT_Q2) && (wrSawQ2Reg || phase == PSP_Q2)
                          && !wrDone;
            rdSawQ2Reg <= (rdStateReg == PSP_WAIT_Q2) && (rdSawQ2Reg || phase == PSP_Q2)
                          && !rdDone;
        end
    end

    assign wrDone = wrStateReg == PSP_WAIT_Q2 && wrSawQ2Reg && phase == PSP_Q4;
    assign rdDone = rdStateReg == PSP_WAIT_Q2 && rdSawQ2Reg && phase == PSP_Q4;

    logic wrFirst;
    logic rdFirst;
    assign wrFirst = wrStart && wrStateReg == PSP_IDLE;
    assign rdFirst = rdStart && rdStateReg == PSP_IDLE;

    // host data: capture on first detection and follow while strobe held
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            inLatchReg <= 8'h00;
        end else if (wrStart) begin
            inLatchReg <= dataSync;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            outLatchReg <= 8'h00;
        end else if (wrData) begin
            outLatchReg <= pwdata[7:0];
        end
    end

    // flag set wins over a firmware clear in the same cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ibfReg <= 1'b0;
        end else if (!modeReg) begin
            ibfReg <= 1'b0;
        end else if (wrDone) begin
            ibfReg <= 1'b1;
        end else if (rdData) begin
            ibfReg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            obfReg <= 1'b0;
        end else if (!modeReg) begin
            obfReg <= 1'b0;
        end else if (rdFirst) begin
            obfReg <= 1'b0;
        end else if (wrData) begin
            obfReg <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ibovReg <= 1'b0;
        end else if (wrFirst && ibfReg) begin
            ibovReg <= 1'b1;
        end else if (wrDirStat && !pwdata[`PSP_BIT_IN_BUFFER_OVERRUN]) begin
            ibovReg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            modeReg <= 1'b0;
            dirReg  <= 3'(`PSP_RST_DIRSTAT);
        end else if (wrDirStat) begin
            modeReg <= pwdata[`PSP_BIT_MODE];
            dirReg  <= pwdata[2:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irqFlagReg      <= 1'b0;
            irqFlagOtherReg <= 7'h00;
        end else begin
            if (wrDone || rdDone) begin
                irqFlagReg <= 1'b1;
            end else if (wrIrqFlag) begin
                irqFlagReg <= pwdata[`PSP_BIT_IRQ];
            end
            if (wrIrqFlag) begin
                irqFlagOtherReg <= pwdata[6:0];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irqEnReg      <= `PSP_RST_IRQEN;
            anaCfgReg     <= `PSP_RST_ANACFG;
            portELatchReg <= 3'h0;
        end else begin
            if (apbWr && addr.index == `PSP_IDX_IRQEN) begin
                irqEnReg <= pwdata[7:0];
            end
            if (apbWr && addr.index == `PSP_IDX_ANACFG) begin
                anaCfgReg <= pwdata[7:0];
            end
            if (apbWr && addr.index == `PSP_IDX_PORT_E_PINS) begin
                portELatchReg <= pwdata[2:0];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            slavePortIrq <= 1'b0;
        end else begin
            slavePortIrq <= irqFlagReg && irqEnReg[`PSP_BIT_IRQ];
        end
    end

    // data pins: host read drives, otherwise port-D direction in I/O mode
    logic [7:0] dataOeNext;
    assign dataOeNext = modeReg ? {8{rdStart}} : ~portDDirection;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dataPinOe  <= 8'h00;
            dataPinOut <= 8'h00;
        end else begin
            dataPinOe  <= dataOeNext;
            dataPinOut <= outLatchReg;
        end
    end

    // port-E: strobes are inputs in slave mode; general I/O otherwise
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            portEPinOe  <= 3'h0;
            portEPinOut <= 3'h0;
        end else begin
            portEPinOe  <= modeReg ? 3'h0 : ~dirReg;
            portEPinOut <= portELatchReg;
        end
    end

    logic [7:0] portERead;
    assign portERead = pinsDigital ? {5'h00, strbSync} : 8'h00;

    always_comb begin
        prdata = 32'h0000_0000;
        if (apbRd) begin
            case (addr.index)
                `PSP_IDX_DATA:    prdata[7:0] = modeReg ? inLatchReg : dataSync;
                `PSP_IDX_PORT_E_PINS:   prdata[7:0] = portERead;
                `PSP_IDX_IRQFLAG: prdata[7:0] = {irqFlagReg, irqFlagOtherReg};
                `PSP_IDX_DIRSTAT: prdata[7:0] = {ibfReg, obfReg, ibovReg, modeReg,
                                                 1'b0, dirReg};
                `PSP_IDX_IRQEN:   prdata[7:0] = irqEnReg;
                `PSP_IDX_ANACFG:  prdata[7:0] = anaCfgReg;
                default:          prdata      = 32'h0000_0000;
            endcase
        end
    end

    property p_ibf_clear_outside_mode;
        @(posedge clk_sys) disable iff (rst) !modeReg |=> !ibfReg;
    endproperty
    a_ibf_clear_outside_mode: assert property (p_ibf_clear_outside_mode)
        else $error("input full set outside slave mode");

    property p_ibf_set_on_q4;
        @(posedge clk_sys) disable iff (rst) $rose(ibfReg) |-> $past(phase) == PSP_Q4;
    endproperty
    a_ibf_set_on_q4: assert property (p_ibf_set_on_q4)
        else $error("input full set off phase four");

    property p_irq_with_ibf;
        @(posedge clk_sys) disable iff (rst) $rose(ibfReg) |-> irqFlagReg;
    endproperty
    a_irq_with_ibf: assert property (p_irq_with_ibf)
        else $error("interrupt flag not set with input full");

    property p_obf_cleared_on_read;
        @(posedge clk_sys) disable iff (rst) rdFirst |=> !obfReg;
    endproperty
    a_obf_cleared_on_read: assert property (p_obf_cleared_on_read)
        else $error("output full not cleared at read start");

    property p_in_buffer_overrun_on_second_write;
        @(posedge clk_sys) disable iff (rst) (wrFirst && ibfReg) |=> ibovReg;
    endproperty
    a_in_buffer_overrun_on_second_write: assert property (p_in_buffer_overrun_on_second_write)
        else $error("overrun not flagged");

    property p_irq_gated;
        @(posedge clk_sys) disable iff (rst) slavePortIrq |-> $past(irqEnReg[`PSP_BIT_IRQ]);
    endproperty
    a_irq_gated: assert property (p_irq_gated)
        else $error("interrupt raised while disabled");

    property p_obf_set_by_fw;
        @(posedge clk_sys) disable iff (rst) $rose(obfReg) |-> $past(wrData);
    endproperty
    a_obf_set_by_fw: assert property (p_obf_set_by_fw)
        else $error("output full set without firmware write");

    property p_wr_done_bound;
        @(posedge clk_sys) disable iff (rst)
            (wrStateReg == PSP_ACTIVE && !wrStart && modeReg) |-> ##[1:9] wrDone || !modeReg;
    endproperty
    a_wr_done_bound: assert property (p_wr_done_bound)
        else $error("write completion late");

    property p_ibf_only_read_clears;
        @(posedge clk_sys) disable iff (rst)
            ($fell(ibfReg) && $past(modeReg) && modeReg) |-> $past(rdData);
    endproperty
    a_ibf_only_read_clears: assert property (p_ibf_only_read_clears)
        else $error("input full cleared without data read");
endmodule : psp_slave_port
`default_nettype wire

// ==== psp_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module psp_host_model (
    input  wire logic       clk_sys,
    input  wire logic [7:0] dataPinOut,
    input  wire logic [7:0] dataPinOe,
    output logic      [2:0] portEPinIn,
    output logic      [7:0] dataPinIn
);
    // strobe bits are {chip select, write, read}, all active low, idle high
    initial begin
        portEPinIn = 3'h7;
        dataPinIn  = 8'h00;
    end

    task automatic host_write(input logic selN, input logic [7:0] d, input int hold);
        @(posedge clk_sys);
        dataPinIn  <= d;
        portEPinIn <= {selN, 2'b01};
        repeat (hold) @(posedge clk_sys);
        portEPinIn <= 3'h7;
        @(posedge clk_sys);
        // a released bus must not keep showing the byte just written
        dataPinIn <= ~d;
    endtask : host_write

    task automatic host_read(input int hold, output logic [7:0] d, output logic ok);
        @(posedge clk_sys);
        portEPinIn <= 3'b010;
        repeat (hold) @(posedge clk_sys);
        @(negedge clk_sys);
        d  = dataPinOut;
        ok = (dataPinOe === 8'hFF);
        @(posedge clk_sys);
        portEPinIn <= 3'h7;
    endtask : host_read
endmodule : psp_host_model
`default_nettype wire

// ==== psp_slave_port_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "psp_regs.svh"
module psp_slave_port_tb_top;
    import psp_pkg::*;
    logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, slavePortIrq;
    logic        rdErr, readOk;
    logic [31:0] paddr, pwdata, prdata, rdData;
    logic [7:0]  dataPinIn, dataPinOut, dataPinOe, portDDirection, hostByte, wrByte;
    logic [2:0]  portEPinIn, portEPinOut, portEPinOe;
    int          numErrors, testsRun, seed, i;

    psp_slave_port i_psp_slave_port (.clk_sys(clk_sys), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .dataPinIn(dataPinIn), .dataPinOut(dataPinOut),
        .dataPinOe(dataPinOe), .portDDirection(portDDirection), .portEPinIn(portEPinIn),
        .portEPinOut(portEPinOut), .portEPinOe(portEPinOe), .slavePortIrq(slavePortIrq));
    psp_host_model i_psp_host_model (.clk_sys(clk_sys), .dataPinOut(dataPinOut),
        .dataPinOe(dataPinOe), .portEPinIn(portEPinIn), .dataPinIn(dataPinIn));

    function automatic logic [31:0] adr(input logic [7:0] idx);
        return {22'h0, idx, 2'b00};
    endfunction : adr

    function automatic logic [31:0] dirstat(input logic in_buffer_full, out_buffer_full, in_buffer_overrun, mode);
        return {24'h0, in_buffer_full, out_buffer_full, in_buffer_overrun, mode, 4'h7};
    endfunction : dirstat

    function automatic logic [31:0] port_e_pins_exp(input logic [7:0] ana, input logic [2:0] pins);
        return (ana[3:0] >= `PSP_ANA_DIGITAL_MIN) ? {29'h0, pins} : 32'h0;
    endfunction : port_e_pins_exp

    task automatic print_verdict;
        if (numErrors == 0 && testsRun > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        testsRun++;
        if (got !== exp) begin
            numErrors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        logic rdy;
        rdy = 1'b0;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // request stands until pready is seen high at a rising edge
        for (int n = 0; n < 16 && !rdy; n++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) begin
                rdy    = 1'b1;
                rdData = prdata;
                rdErr  = pslverr;
            end
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        if (!rdy) begin
            numErrors++;
            print_verdict();
        end
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, adr(idx), {24'h0, d});
    endtask : wr

    task automatic expect_reg(input string what, input logic [7:0] idx, input logic [31:0] e);
        apb(1'b0, adr(idx), 32'h0);
        chk(what, e, rdData);
    endtask : expect_reg

    task automatic wait_bit(input logic [7:0] idx, input int b);
        for (int n = 0; n < 20; n++) begin
            apb(1'b0, adr(idx), 32'h0);
            if (rdData[b] === 1'b1) break;
        end
        chk("flag wait", 32'h1, {31'h0, rdData[b]});
    endtask : wait_bit

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        numErrors++;
        print_verdict();
    end

    initial begin
        seed = 67;
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        portDDirection = 8'hFF;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        expect_reg("dirstat", `PSP_IDX_DIRSTAT, {24'h0, `PSP_RST_DIRSTAT});
        expect_reg("irqflag", `PSP_IDX_IRQFLAG, {24'h0, `PSP_RST_IRQFLAG});
        expect_reg("irqen", `PSP_IDX_IRQEN, {24'h0, `PSP_RST_IRQEN});
        expect_reg("port_e_pins", `PSP_IDX_PORT_E_PINS, port_e_pins_exp(`PSP_RST_ANACFG, 3'h7));
        apb(1'b0, 32'h0000_0100, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, rdErr});
        wr(`PSP_IDX_ANACFG, 8'h06);
        expect_reg("port_e_pins digital", `PSP_IDX_PORT_E_PINS, port_e_pins_exp(8'h06, 3'h7));
        wr(`PSP_IDX_DIRSTAT, 8'h02);
        wr(`PSP_IDX_PORT_E_PINS, 8'h05);
        portDDirection <= 8'($random(seed));
        repeat (3) @(posedge clk_sys);
        chk("port_e_pins oe", 32'h5, {29'h0, portEPinOe});
        chk("port_e_pins out", 32'h5, {29'h0, portEPinOut});
        chk("data oe", {24'h0, ~portDDirection}, {24'h0, dataPinOe});
        wr(`PSP_IDX_DIRSTAT, 8'h17);
        wr(`PSP_IDX_IRQEN, 8'h80);
        portDDirection <= 8'h00;
        repeat (3) @(posedge clk_sys);
        chk("slave oe idle", 32'h0, {24'h0, dataPinOe});
        for (i = 0; i < 4; i++) begin
            wrByte = 8'($random(seed));
            wr(`PSP_IDX_DATA, wrByte);
            expect_reg("obf set", `PSP_IDX_DIRSTAT, dirstat(0, 1, 0, 1));
            i_psp_host_model.host_read((i % 2) ? 12 : 5, hostByte, readOk);
            chk("host read", {24'h0, wrByte}, {24'h0, hostByte});
            chk("host read drive", 32'h1, {31'h0, readOk});
            expect_reg("obf clear", `PSP_IDX_DIRSTAT, dirstat(0, 0, 0, 1));
            wait_bit(`PSP_IDX_IRQFLAG, `PSP_BIT_IRQ);
            // the interrupt output is registered one clock behind the flag
            repeat (2) @(posedge clk_sys);
            chk("irq out", 32'h1, {31'h0, slavePortIrq});
            wr(`PSP_IDX_IRQFLAG, 8'h00);
            hostByte = 8'($random(seed));
            i_psp_host_model.host_write(1'b0, hostByte, (i % 2) ? 9 : 3);
            wait_bit(`PSP_IDX_DIRSTAT, `PSP_BIT_IBF);
            expect_reg("irq on write", `PSP_IDX_IRQFLAG, 32'h80);
            wr(`PSP_IDX_DATA, 8'h00);
            expect_reg("ibf kept", `PSP_IDX_DIRSTAT, dirstat(1, 1, 0, 1));
            expect_reg("input latch", `PSP_IDX_DATA, {24'h0, hostByte});
            expect_reg("ibf cleared", `PSP_IDX_DIRSTAT, dirstat(0, 1, 0, 1));
            wr(`PSP_IDX_IRQFLAG, 8'h00);
            repeat (2) @(posedge clk_sys);
            chk("irq cleared", 32'h0, {31'h0, slavePortIrq});
        end
        i_psp_host_model.host_write(1'b1, 8'hA5, 6);
        repeat (20) @(posedge clk_sys);
        expect_reg("deselected write", `PSP_IDX_DIRSTAT, dirstat(0, 1, 0, 1));
        i_psp_host_model.host_write(1'b0, 8'h3C, 2);
        wait_bit(`PSP_IDX_DIRSTAT, `PSP_BIT_IBF);
        i_psp_host_model.host_write(1'b0, 8'hC3, 2);
        repeat (20) @(posedge clk_sys);
        expect_reg("overrun", `PSP_IDX_DIRSTAT, dirstat(1, 1, 1, 1));
        wr(`PSP_IDX_IRQEN, 8'h00);
        repeat (2) @(posedge clk_sys);
        chk("irq masked", 32'h0, {31'h0, slavePortIrq});
        wr(`PSP_IDX_DIRSTAT, 8'h27);
        expect_reg("mode off", `PSP_IDX_DIRSTAT, 32'h27);
        wr(`PSP_IDX_DIRSTAT, 8'h07);
        expect_reg("overrun cleared", `PSP_IDX_DIRSTAT, 32'h07);
        print_verdict();
    end
endmodule : psp_slave_port_tb_top
`default_nettype wire
